// File: core/quadrature_correction_gain_phase.v
// Quadrature correction: per-channel gain, first-pair phase correction,
// shadowed first-pair settings with auto-sync, and output delay.
// Assumes a single AHB-Lite master issuing single word transfers and
// samples synchronous to hclk, presented while ce is high.
//
// The AHB-Lite register port was left to the implementer.
`default_nettype none
`include "qmc_consts.vh"

// Function
// - Third channel scaled by 11-bit unsigned gain, ten fraction bits, unity at reset.
// - Fourth channel scaled by its own 11-bit unsigned gain, same format.
// - Sample outputs and out_valid_q delayed by 0 to 3 cycles, field 15:14, reset zero; bus outputs are not delayed.
// - First-pair phase is 12-bit two's complement fraction, reset zero.
// - Second sample times phase is added into the first sample.
// - With auto-sync enabled, writing the phase register raises a sync event.
// - Sync event loads first-pair gains and phase into active set together.
// - First-pair gain writes only reach shadow storage until the sync.
module quadrature_correction_gain_phase (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout_q,
  output reg hresp_q,
  output reg [31:0] hrdata_q,
  input wire sample_valid,
  input wire [15:0] sample_a,
  input wire [15:0] sample_b,
  input wire [15:0] sample_c,
  input wire [15:0] sample_d,
  output reg out_valid_q,
  output reg [15:0] out_a_q,
  output reg [15:0] out_b_q,
  output reg [15:0] out_c_q,
  output reg [15:0] out_d_q
);

  localparam SW = `SAMPLE_W;
  localparam LANE_W = `NUM_CH * SW + 1;

  // Bus address phase capture
  reg wr_pend_q;
  reg [5:0] wr_idx_q;
  wire addr_ok = hsel & htrans[1] & hready;
  wire [5:0] a_idx = haddr[`IDX_MSB:`IDX_LSB];

  // Register state: shadows, directly used fields, active first-pair set
  reg [`GAIN_MSB:0] first_gain_sh_q;
  reg [`GAIN_MSB:0] second_gain_sh_q;
  reg [`PHASE_MSB:0] phase_sh_q;
  reg [`GAIN_MSB:0] third_channel_gain_word_q;
  reg [`GAIN_MSB:0] fourth_channel_gain_word_q;
  reg [1:0] out_delay_q;
  reg auto_sync_en_q;
  reg [`GAIN_MSB:0] first_gain_act_q;
  reg [`GAIN_MSB:0] second_gain_act_q;
  reg [`PHASE_MSB:0] first_pair_phase_word_q;

  wire wr_phase = wr_pend_q & (wr_idx_q == `IDX_FIRST_PAIR_PHASE);
  wire wr_ctrl = wr_pend_q & (wr_idx_q == `IDX_SYNC_CTRL);
  // Manual sync lets software load the shadows while auto-sync is off
  wire sync_evt = (wr_phase & auto_sync_en_q) | (wr_ctrl & hwdata[`SYNC_NOW_BIT]);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
      hreadyout_q <= 1'b1;
      hresp_q <= `HRESP_OKAY;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= `HRESP_OKAY;
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok)
        wr_idx_q <= a_idx;
    end
  end

  // Only the documented fields are stored; reserved bits are dropped
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_gain_sh_q <= `GAIN_RST;
      second_gain_sh_q <= `GAIN_RST;
      phase_sh_q <= `PHASE_RST;
      third_channel_gain_word_q <= `GAIN_RST;
      fourth_channel_gain_word_q <= `GAIN_RST;
      out_delay_q <= `DELAY_RST;
      auto_sync_en_q <= 1'b0;
    end
    else if (wr_pend_q)
    begin
      if (wr_idx_q == `IDX_FIRST_GAIN)
        first_gain_sh_q <= hwdata[`GAIN_MSB:0];
      else if (wr_idx_q == `IDX_SECOND_GAIN)
        second_gain_sh_q <= hwdata[`GAIN_MSB:0];
      else if (wr_idx_q == `IDX_THIRD_GAIN)
        third_channel_gain_word_q <= hwdata[`GAIN_MSB:0];
      else if (wr_idx_q == `IDX_FOURTH_GAIN_DELAY)
      begin
        fourth_channel_gain_word_q <= hwdata[`GAIN_MSB:0];
        out_delay_q <= hwdata[`DELAY_MSB:`DELAY_LSB];
      end
      else if (wr_idx_q == `IDX_FIRST_PAIR_PHASE)
        phase_sh_q <= hwdata[`PHASE_MSB:0];
      else if (wr_idx_q == `IDX_SYNC_CTRL)
        auto_sync_en_q <= hwdata[`SYNC_EN_BIT];
    end
  end

  // Phase written in the sync cycle goes straight in, so all three land together
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_gain_act_q <= `GAIN_RST;
      second_gain_act_q <= `GAIN_RST;
      first_pair_phase_word_q <= `PHASE_RST;
    end
    else if (sync_evt)
    begin
      first_gain_act_q <= first_gain_sh_q;
      second_gain_act_q <= second_gain_sh_q;
      first_pair_phase_word_q <= wr_phase ? hwdata[`PHASE_MSB:0] : phase_sh_q;
    end
  end

  // Read data registered in the address phase; unmapped reads return zero
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= `HRDATA_ZERO;
    else if (addr_ok & ~hwrite)
    begin
      if (a_idx == `IDX_FIRST_GAIN)
        hrdata_q <= {21'h000000, first_gain_sh_q};
      else if (a_idx == `IDX_SECOND_GAIN)
        hrdata_q <= {21'h000000, second_gain_sh_q};
      else if (a_idx == `IDX_THIRD_GAIN)
        hrdata_q <= {21'h000000, third_channel_gain_word_q};
      else if (a_idx == `IDX_FOURTH_GAIN_DELAY)
        hrdata_q <= {16'h0000, out_delay_q, 3'h0, fourth_channel_gain_word_q};
      else if (a_idx == `IDX_FIRST_PAIR_PHASE)
        hrdata_q <= {20'h00000, phase_sh_q};
      else if (a_idx == `IDX_SYNC_CTRL)
        hrdata_q <= {31'h00000000, auto_sync_en_q};
      else
        hrdata_q <= `HRDATA_ZERO;
    end
  end

  // Clamp to the 16-bit signed sample range
  function [15:0] sat16;
    input signed [18:0] v;
    begin
      if (v > $signed(19'h07fff))
        sat16 = 16'h7fff;
      else if (v < $signed(19'h78000))
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  wire [SW*`NUM_CH-1:0] samp_in = {sample_d, sample_c, sample_b, sample_a};
  wire [(`GAIN_MSB+1)*`NUM_CH-1:0] gains = {fourth_channel_gain_word_q,
    third_channel_gain_word_q, second_gain_act_q, first_gain_act_q};
  wire [19*`NUM_CH-1:0] scaled;

  // Unsigned gain made signed by a zero sign bit; ten fraction bits dropped
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1)
    begin : g_gain
      wire signed [15:0] s = samp_in[ch*SW +: SW];
      wire signed [11:0] g = {1'b0, gains[ch*(`GAIN_MSB+1) +: (`GAIN_MSB+1)]};
      wire signed [27:0] p = s * g;
      assign scaled[ch*19 +: 19] = {p[27], p[27:`GAIN_FRAC]};
    end
  endgenerate

  // Phase term: second sample times a fraction with twelve fraction bits
  wire signed [15:0] samp_b_s = sample_b;
  wire signed [11:0] phase_s = first_pair_phase_word_q;
  wire signed [27:0] phase_prod = samp_b_s * phase_s;
  wire signed [18:0] phase_term = {{3{phase_prod[27]}}, phase_prod[27:`PHASE_FRAC]};
  wire signed [18:0] first_sum = $signed(scaled[18:0]) + phase_term;

  reg [LANE_W-1:0] stage_q;
  wire [LANE_W-1:0] delayed;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stage_q <= {LANE_W{1'b0}};
    else if (ce)
      stage_q <= {sample_valid, sat16(scaled[3*19 +: 19]), sat16(scaled[2*19 +: 19]),
        sat16(scaled[19 +: 19]), sat16(first_sum)};
  end

  sample_delay_line #(
    .WIDTH(LANE_W)
  ) i_sample_delay_line (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .delay_sel(out_delay_q),
    .din(stage_q),
    .dout_q(delayed)
  );

  // Final output stage keeps every output on its own flip-flop
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid_q <= 1'b0;
      out_a_q <= 16'h0000;
      out_b_q <= 16'h0000;
      out_c_q <= 16'h0000;
      out_d_q <= 16'h0000;
    end
    else if (ce)
    begin
      out_valid_q <= delayed[LANE_W-1];
      out_a_q <= delayed[SW-1:0];
      out_b_q <= delayed[2*SW-1:SW];
      out_c_q <= delayed[3*SW-1:2*SW];
      out_d_q <= delayed[4*SW-1:3*SW];
    end
  end

endmodule

`default_nettype wire

// File: core/qmc_consts.vh
// Constants for the quadrature correction block: register indexes,
// field positions, reset values and fixed-point scaling.
// Assumes AHB-Lite word addressing: byte address is four times the index.
`ifndef QMC_CONSTS_VH
`define QMC_CONSTS_VH

// Register indexes (word address = haddr[7:2])
`define IDX_FIRST_GAIN 6'h0c
`define IDX_SECOND_GAIN 6'h0d
`define IDX_THIRD_GAIN 6'h0e
`define IDX_FOURTH_GAIN_DELAY 6'h0f
`define IDX_FIRST_PAIR_PHASE 6'h10
`define IDX_SYNC_CTRL 6'h1e
`define IDX_MSB 7
`define IDX_LSB 2

// Field layout
`define GAIN_MSB 10
`define DELAY_MSB 15
`define DELAY_LSB 14
`define PHASE_MSB 11
`define SYNC_EN_BIT 0
`define SYNC_NOW_BIT 1

// Reset values
`define GAIN_RST 11'h400
`define DELAY_RST 2'h0
`define PHASE_RST 12'h000

// Fixed-point scaling: gain has 10 fraction bits, phase 12
`define GAIN_FRAC 10
`define PHASE_FRAC 12

// Sample path
`define SAMPLE_W 16
`define NUM_CH 4
`define MAX_DELAY 3

// AHB-Lite codes
`define HRESP_OKAY 1'h0
`define HRDATA_ZERO 32'h0000_0000

`endif

// File: core/sample_delay_line.v
// Programmable delay of 0 to MAX_DELAY clock-enabled cycles.
// Assumes the delay select is stable between samples; output is registered.
`default_nettype none
`include "qmc_consts.vh"

module sample_delay_line #(
  parameter WIDTH = 65
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire [1:0] delay_sel,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout_q
);

  reg [WIDTH-1:0] tap_q [0:`MAX_DELAY-1];

  genvar i;
  generate
    for (i = 0; i < `MAX_DELAY; i = i + 1)
    begin : g_tap
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          tap_q[i] <= {WIDTH{1'b0}};
        else if (ce)
          tap_q[i] <= (i == 0) ? din : tap_q[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dout_q <= {WIDTH{1'b0}};
    else if (ce)
    begin
      if (delay_sel == 2'h0)
        dout_q <= din;
      else
        dout_q <= tap_q[delay_sel - 2'h1];
    end
  end

endmodule

`default_nettype wire

// File: tb/qmc_asserts.sv
// Checker for the quadrature correction block, bound to its top module.
// Assumes word transfers and a bench that holds ce low while it writes settings.
`default_nettype none
`include "qmc_consts.vh"
module qmc_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata_q,
  input wire logic sample_valid,
  input wire logic [15:0] sample_a,
  input wire logic [15:0] sample_b,
  input wire logic [15:0] sample_c,
  input wire logic out_valid_q,
  input wire logic [15:0] out_a_q,
  input wire logic [15:0] out_b_q,
  input wire logic [15:0] out_c_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic aw_q, en_q, sync;
  logic [5:0] ai_q;
  logic [10:0] g1s_q, g2s_q, g1a_q, g2a_q, g3_q, g4_q;
  logic [11:0] phs_q, pha_q;
  logic [1:0] dly_q;
  function automatic logic signed [31:0] mul(input logic signed [15:0] s,
    input logic signed [12:0] k, input int sh);
    logic signed [31:0] p;
    p = s * k;
    return p >>> sh;
  endfunction
  function automatic logic [15:0] sat(input int v);
    return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : 16'(v);
  endfunction
  // Manual sync takes the phase shadow, a phase write takes the new word
  assign sync = aw_q && ((ai_q == 6'h10 && en_q) || (ai_q == 6'h1e && hwdata[1]));
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {aw_q, en_q, dly_q, phs_q, pha_q, ai_q} <= '0;
      {g1s_q, g2s_q, g1a_q, g2a_q, g3_q, g4_q} <= {6{`GAIN_RST}};
    end
    else
    begin
      aw_q <= hsel && htrans[1] && hready && hwrite;
      ai_q <= haddr[7:2];
      if (aw_q && ai_q == 6'h0c) g1s_q <= hwdata[10:0];
      if (aw_q && ai_q == 6'h0d) g2s_q <= hwdata[10:0];
      if (aw_q && ai_q == 6'h0e) g3_q <= hwdata[10:0];
      if (aw_q && ai_q == 6'h0f) {dly_q, g4_q} <= {hwdata[15:14], hwdata[10:0]};
      if (aw_q && ai_q == 6'h10) phs_q <= hwdata[11:0];
      if (aw_q && ai_q == 6'h1e) en_q <= hwdata[0];
      if (sync) {g1a_q, g2a_q, pha_q} <= {g1s_q, g2s_q, ai_q == 6'h10 ? hwdata[11:0] : phs_q};
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [5:0] i);
    hsel && htrans[1] && hready && !hwrite && haddr[7:2] == i;
  endsequence
  // Capture, delay-line and output edges all enabled at delay zero
  sequence fresh0;
    (ce && dly_q == 2'h0)[*3];
  endsequence
  chk_gain_third: assert property (fresh0 |=>
    out_c_q == sat(mul($past(sample_c, 3), {2'h0, g3_q}, 10))) else $error("third gain");
  chk_phase_sum: assert property (fresh0 |=>
    out_a_q == sat(mul($past(sample_a, 3), {2'h0, g1a_q}, 10)
    + mul($past(sample_b, 3), {pha_q[11], pha_q}, 12))) else $error("phase sum");
  chk_shadow_hold: assert property (fresh0 |=>
    out_b_q == sat(mul($past(sample_b, 3), {2'h0, g2a_q}, 10))) else $error("second gain");
  chk_valid_zero: assert property (fresh0 |=>
    out_valid_q == $past(sample_valid, 3)) else $error("valid at delay zero");
  chk_delay_three: assert property ((ce && dly_q == 2'h3)[*6] |=>
    out_valid_q == $past(sample_valid, 6)) else $error("valid at delay three");
  chk_read_third: assert property (rd_at(6'h0e) |=>
    hrdata_q == {21'h0, g3_q}) else $error("third gain readback");
  chk_read_fourth: assert property (rd_at(6'h0f) |=>
    hrdata_q == {16'h0, dly_q, 3'h0, g4_q}) else $error("fourth gain readback");
  chk_read_phase: assert property (rd_at(6'h10) |=>
    hrdata_q == {20'h0, phs_q}) else $error("phase readback");
endmodule
bind quadrature_correction_gain_phase qmc_asserts i_qmc_asserts (.hclk, .hresetn, .ce,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata_q, .sample_valid, .sample_a,
  .sample_b, .sample_c, .out_valid_q, .out_a_q, .out_b_q, .out_c_q);
`default_nettype wire

// File: tb/tb_quadrature_correction_gain_phase.sv
// Self-checking bench for the quadrature correction block.
// Assumes a zero-wait AHB-Lite slave and a 100 MHz clock.
`default_nettype none
module tb_quadrature_correction_gain_phase;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [4:0][31:0] w;
    logic [3:0][15:0] s;
    logic [3:0][15:0] e;
    int dl;
  } row_t;
  logic hclk, hresetn, ce, hsel, hwrite, hready, sample_valid;
  logic hreadyout_q, hresp_q, out_valid_q;
  logic [31:0] haddr, hwdata, hrdata_q, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] sample_a, sample_b, sample_c, sample_d, out_a_q, out_b_q, out_c_q, out_d_q;
  logic [3:0][15:0] outs;
  int n_fail = 0;
  int checks_done = 0;
  // Words for 0x0c..0x10, phase last; reserved bits set on purpose
  row_t rows [4] = '{
    '{{32'h0, 32'h4400, 32'h400, 32'h400, 32'h400},
      {16'h8000, 16'h7fff, 16'hfffb, 16'h1234}, {16'h8000, 16'h7fff, 16'hfffb, 16'h1234}, 1},
    '{{32'hffff_f800, 32'hffff_3a00, 32'hffff_ffff, 32'h0, 32'h400},
      {16'h8000, 16'h4000, 16'h1000, 16'h0100}, {16'hc000, 16'h7ff0, 16'h0000, 16'hf900}, 0},
    '{{32'h7ff, 32'hc000, 32'h7ff, 32'h400, 32'h400},
      {16'h1234, 16'h7fff, 16'h7fff, 16'h7f00}, {16'h0000, 16'h7fff, 16'h7fff, 16'h7fff}, 3},
    '{{32'hffff_f001, 32'hffff_bc00, 32'hffff_f801, 32'h400, 32'h0},
      {16'h0001, 16'hffff, 16'hfffe, 16'h0000}, {16'h0001, 16'hffff, 16'hfffe, 16'hffff}, 2}};
  assign hready = hreadyout_q;
  assign outs = {out_d_q, out_c_q, out_b_q, out_a_q};
  quadrature_correction_gain_phase i_quadrature_correction_gain_phase (.*);
  task end_of_test();
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic [5:0] i, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, i, 2'h0};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout_q !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout_q !== 1'b1) @(posedge hclk);
    rdat = hrdata_q;
  endtask
  task rchk(input logic [5:0] i, input logic [31:0] exp);
    xfer(i, 1'b0, 32'h0);
    chk(rdat, exp);
    chk({hreadyout_q, hresp_q}, 64'h2);
  endtask
  // Zeros first, as taps keep samples from an earlier delay setting;
  // then one sample set and zeros, so a late or early valid shows in the count
  task strm(input logic [3:0][15:0] s, input logic [3:0][15:0] e, input int dl);
    int n;
    @(posedge hclk);
    ce <= 1'b1;
    repeat (5) @(posedge hclk);
    sample_valid <= 1'b1;
    {sample_d, sample_c, sample_b, sample_a} <= s;
    @(posedge hclk);
    sample_valid <= 1'b0;
    {sample_d, sample_c, sample_b, sample_a} <= '0;
    n = 0;
    while (out_valid_q !== 1'b1 && n < 9)
    begin
      @(negedge hclk);
      n++;
    end
    // Output edge is 2 + dl edges after capture, seen at the negedge after it
    chk(n, 3 + dl);
    chk(outs, e);
    @(posedge hclk);
    ce <= 1'b0;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial
  begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    {hresetn, ce, hsel, htrans, hwrite, haddr, hwdata, sample_valid} = '0;
    {sample_a, sample_b, sample_c, sample_d} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(6'h1e, 1'b1, 32'h1);
    foreach (rows[j])
    begin
      for (int k = 0; k < 5; k++)
        xfer(6'h0c + 6'(k), 1'b1, rows[j].w[k]);
      strm(rows[j].s, rows[j].e, rows[j].dl);
    end
    rchk(6'h0e, 32'h001);
    rchk(6'h0f, 32'h8400);
    rchk(6'h10, 32'h001);
    rchk(6'h3f, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(6'h0e, 32'h400);
    rchk(6'h0f, 32'h400);
    rchk(6'h10, 32'h0);
    // Auto-sync is off after reset, so these stay in the shadow
    xfer(6'h0d, 1'b1, 32'h200);
    xfer(6'h10, 1'b1, 32'h800);
    strm(64'h1000_0000, 64'h1000_0000, 0);
    xfer(6'h1e, 1'b1, 32'h1);
    xfer(6'h10, 1'b1, 32'h800);
    strm(64'h1000_0000, 64'h0800_f800, 0);
    // Gain write with auto-sync on stays shadowed until a manual sync
    xfer(6'h0d, 1'b1, 32'h400);
    strm(64'h1000_0000, 64'h0800_f800, 0);
    xfer(6'h1e, 1'b1, 32'h3);
    strm(64'h1000_0000, 64'h1000_f800, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
